// file: verilog/ric_pkg.sv
package ric_pkg;

  localparam logic [7:0] IOR_ADDR = 8'hc8;
  localparam logic [7:0] STATUS_ADDR = 8'hcc;

  localparam int LES_BIT = 6;
  localparam int ESB_BIT = 5;
  localparam int GEN_BIT = 4;
  localparam logic [7:0] IOR_RESET = 8'h00;
  localparam logic [7:0] IOR_MASK = 8'h70;

  localparam int RESET_DELAY_CYCLES = 2048;
  localparam int FETCH_CYCLES = 2;
  localparam int WDG_IND_CYCLES = 4;
  localparam int CNT_W = 12;

  localparam logic [11:0] VEC_RESET = 12'hffe;
  localparam logic [11:0] VEC_NMI = 12'hffc;
  localparam logic [11:0] VEC_1 = 12'hff6;
  localparam logic [11:0] VEC_2 = 12'hff4;
  localparam logic [11:0] VEC_3 = 12'hff2;
  localparam logic [11:0] VEC_4 = 12'hff0;

  localparam logic [2:0] SRC_NMI = 3'h0;
  localparam logic [2:0] SRC_V1 = 3'h1;
  localparam logic [2:0] SRC_V2 = 3'h2;
  localparam logic [2:0] SRC_V3 = 3'h3;
  localparam logic [2:0] SRC_V4 = 3'h4;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_DELAY = 2'b01,
    ST_FETCH = 2'b10,
    ST_RUN = 2'b11
  } rst_state_type;

endpackage : ric_pkg

// file: verilog/reset_and_interrupt_control.sv
// Summary of operation
// RULE1: any reset waits 2048 cycles first
// RULE2: reset vector fetch lasts two cycles
// RULE3: reset clears stack, loads 0FFEh
// RULE4: reset enters non-maskable mode until return
// RULE5: reset pin honoured in all modes
// RULE6: short reset pulse still gives full delay
// RULE7: pin reset halts core, pulls up ports
// RULE8: pin reset in stop restarts oscillator
// RULE9: watchdog resets like pin, brief pin pull
// RULE10: low voltage drives pin low throughout
// RULE11: maskable events latch while globally disabled
// RULE12: accepted request loads its fixed vector
// RULE13: reset beats all, nmi never nests
// RULE14: maskable never nest, vector 1 highest
// RULE15: interrupts wake wait; selected wake stop
// RULE16: nmi falling edge latched, cleared on entry
// RULE17: peripheral needs flag, local and global enable
// RULE18: vector 1 edge/level, vector 2 edge
// RULE19: edge latch holds one, cleared on entry
// RULE20: level mode stores nothing, sampled late
// RULE21: rising polarity switch latches one request
// RULE22: stuck active vector 2 pin blocks others
// RULE23: global enable gates all maskable sources
// RULE24: level select: 0 falling, 1 low level
// RULE25: polarity select: 0 falling, 1 rising
// RULE26: nmi without global enable never wakes
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module reset_and_interrupt_control #(
  parameter int RESET_DELAY = ric_pkg::RESET_DELAY_CYCLES,
  parameter int VEC2_PINS = 8,
  parameter bit VEC3_STOP_WAKE = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_n,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic wdg_expire,
  input wire logic lvd_low,
  input wire logic nmi_pin,
  input wire logic vec1_pin,
  input wire logic [VEC2_PINS-1:0] vec2_pins,
  input wire logic per3_flag,
  input wire logic per3_en,
  input wire logic per4_flag,
  input wire logic per4_en,
  input wire logic cpu_wait,
  input wire logic cpu_stop,
  input wire logic instr_done,
  input wire logic return_from_interrupt_instruction,
  output logic cpu_halt,
  output logic vec_fetch,
  output logic stack_clear,
  output logic ports_pullup,
  output logic osc_restart,
  output logic pc_load,
  output logic [11:0] pc_load_addr,
  output logic int_mode_nmi,
  output logic int_mode_mask,
  output logic wake
);

  ric_pkg::rst_state_type state_r;
  logic [ric_pkg::CNT_W-1:0] cnt_r;
  logic [2:0] wdg_cnt_r;
  logic oe_r;
  logic [7:0] ior_r;
  logic in_nmi_r;
  logic in_mask_r;
  logic nmi_prev_r;
  logic nmi_latch_r;
  logic v1_prev_r;
  logic v1_latch_r;
  logic v2_prev_r;
  logic v2_latch_r;
  logic pc_load_r;
  logic [11:0] pc_load_addr_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic reset_req;
  logic gen;
  logic vec1_level_edge_select;
  logic vec2_edge_polarity;
  logic v1_req;
  logic v2_lvl;
  logic p3_req;
  logic p4_req;
  logic acc_valid;
  logic [2:0] acc_src;
  logic [11:0] acc_addr;
  logic fire;
  logic ior_wr;
  logic mask_any;
  logic stop_any;
  default clocking cb_main @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign gen = ior_r[ric_pkg::GEN_BIT];
  assign vec1_level_edge_select = ior_r[ric_pkg::LES_BIT];
  assign vec2_edge_polarity = ior_r[ric_pkg::ESB_BIT];
  // RULE5 RULE9 all sources
  assign reset_req = !reset_pin_n || wdg_expire || lvd_low;
  // reset sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ric_pkg::ST_HOLD;
      cnt_r <= '0;
    end else if (clk_en) begin
      // RULE6 RULE13 restart sequence
      if (reset_req) begin
        state_r <= ric_pkg::ST_HOLD;
        cnt_r <= '0;
      end else begin
        case (state_r)
          ric_pkg::ST_HOLD: begin
            state_r <= ric_pkg::ST_DELAY;
            cnt_r <= '0;
          end
          ric_pkg::ST_DELAY: begin
            // RULE1 start-up delay
            if (cnt_r == ric_pkg::CNT_W'(RESET_DELAY - 1)) begin
              state_r <= ric_pkg::ST_FETCH;
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          ric_pkg::ST_FETCH: begin
            // RULE2 two-cycle fetch
            if (cnt_r == ric_pkg::CNT_W'(ric_pkg::FETCH_CYCLES - 1)) begin
              state_r <= ric_pkg::ST_RUN;
              cnt_r <= '0;
            end else begin
              cnt_r <= cnt_r + 1'b1;
            end
          end
          ric_pkg::ST_RUN: begin
            state_r <= ric_pkg::ST_RUN;
          end
          default: begin
            state_r <= ric_pkg::ST_HOLD;
          end
        endcase
      end
    end
  end
  // RULE7 RULE8 core and port effects
  assign cpu_halt = state_r != ric_pkg::ST_RUN;
  assign ports_pullup = state_r == ric_pkg::ST_HOLD;
  assign osc_restart = state_r == ric_pkg::ST_HOLD;
  // RULE3 stack emptied
  assign stack_clear = state_r == ric_pkg::ST_HOLD;
  assign vec_fetch = state_r == ric_pkg::ST_FETCH;
  // reset pin indication, open drain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdg_cnt_r <= '0;
      oe_r <= 1'b0;
    end else if (clk_en) begin
      // RULE9 brief pull
      if (wdg_expire) begin
        wdg_cnt_r <= 3'(ric_pkg::WDG_IND_CYCLES);
      end else if (wdg_cnt_r != 3'h0) begin
        wdg_cnt_r <= wdg_cnt_r - 1'b1;
      end
      // RULE10 held while low supply
      oe_r <= lvd_low || wdg_expire || (wdg_cnt_r > 3'h1);
    end
  end

  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = oe_r;
  // option register
  assign ior_wr = psel && penable && pready && pwrite && paddr == ric_pkg::IOR_ADDR;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ior_r <= ric_pkg::IOR_RESET;
    end else if (clk_en) begin
      if (state_r == ric_pkg::ST_HOLD) begin
        ior_r <= ric_pkg::IOR_RESET;
      end else if (ior_wr) begin
        ior_r <= pwdata[7:0] & ric_pkg::IOR_MASK;
      end
    end
  end
  // RULE16 nmi edge latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev_r <= 1'b1;
      nmi_latch_r <= 1'b0;
    end else if (clk_en) begin
      nmi_prev_r <= nmi_pin;
      if (state_r == ric_pkg::ST_HOLD) begin
        nmi_latch_r <= 1'b0;
      end else if (nmi_prev_r && !nmi_pin) begin
        nmi_latch_r <= 1'b1;
      end else if (fire && acc_src == ric_pkg::SRC_NMI) begin
        nmi_latch_r <= 1'b0;
      end
    end
  end
  // RULE18 RULE24 vector 1 edge or level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v1_prev_r <= 1'b1;
      v1_latch_r <= 1'b0;
    end else if (clk_en) begin
      v1_prev_r <= vec1_pin;
      if (state_r == ric_pkg::ST_HOLD || vec1_level_edge_select) begin
        v1_latch_r <= 1'b0;
      // RULE11 RULE19 latch once
      end else if (v1_prev_r && !vec1_pin) begin
        v1_latch_r <= 1'b1;
      end else if (fire && acc_src == ric_pkg::SRC_V1) begin
        v1_latch_r <= 1'b0;
      end
    end
  end
  // RULE20 level sampled at instruction end
  assign v1_req = vec1_level_edge_select ? !vec1_pin : v1_latch_r;

  // RULE22 RULE25 pins combined per polarity
  assign v2_lvl = vec2_edge_polarity ? |vec2_pins : ~&vec2_pins;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      v2_prev_r <= 1'b0;
      v2_latch_r <= 1'b0;
    end else if (clk_en) begin
      v2_prev_r <= v2_lvl;
      if (state_r == ric_pkg::ST_HOLD) begin
        v2_latch_r <= 1'b0;
      // RULE19 one pending edge
      end else if (v2_lvl && !v2_prev_r) begin
        v2_latch_r <= 1'b1;
      // RULE21 spurious request on rising select
      end else if (ior_wr && pwdata[ric_pkg::ESB_BIT] && !vec2_edge_polarity) begin
        v2_latch_r <= 1'b1;
      end else if (fire && acc_src == ric_pkg::SRC_V2) begin
        v2_latch_r <= 1'b0;
      end
    end
  end
  // RULE17 RULE23 peripheral gating
  assign p3_req = per3_flag && per3_en && gen;
  assign p4_req = per4_flag && per4_en && gen;
  // arbitration
  always_comb begin
    acc_valid = 1'b0;
    acc_src = ric_pkg::SRC_NMI;
    acc_addr = ric_pkg::VEC_NMI;
    // RULE13 nmi preempts maskable only
    if (nmi_latch_r && !in_nmi_r) begin
      acc_valid = 1'b1;
    // RULE14 RULE23 fixed priority, no nesting
    end else if (gen && !in_nmi_r && !in_mask_r) begin
      if (v1_req) begin
        acc_valid = 1'b1;
        acc_src = ric_pkg::SRC_V1;
        acc_addr = ric_pkg::VEC_1;
      end else if (v2_latch_r) begin
        acc_valid = 1'b1;
        acc_src = ric_pkg::SRC_V2;
        acc_addr = ric_pkg::VEC_2;
      end else if (p3_req) begin
        acc_valid = 1'b1;
        acc_src = ric_pkg::SRC_V3;
        acc_addr = ric_pkg::VEC_3;
      end else if (p4_req) begin
        acc_valid = 1'b1;
        acc_src = ric_pkg::SRC_V4;
        acc_addr = ric_pkg::VEC_4;
      end
    end
  end

  assign fire = clk_en && instr_done && state_r == ric_pkg::ST_RUN && acc_valid;

  // interrupt mode flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_nmi_r <= 1'b1;
      in_mask_r <= 1'b0;
    end else if (clk_en) begin
      if (state_r != ric_pkg::ST_RUN) begin
        // RULE4 start in non-maskable mode
        in_nmi_r <= 1'b1;
        in_mask_r <= 1'b0;
      end else if (fire && acc_src == ric_pkg::SRC_NMI) begin
        in_nmi_r <= 1'b1;
      end else if (fire) begin
        in_mask_r <= 1'b1;
      end else if (return_from_interrupt_instruction) begin
        if (in_nmi_r) begin
          in_nmi_r <= 1'b0;
        end else begin
          in_mask_r <= 1'b0;
        end
      end
    end
  end

  assign int_mode_nmi = in_nmi_r;
  assign int_mode_mask = in_mask_r;
  // program counter load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_load_r <= 1'b0;
      pc_load_addr_r <= ric_pkg::VEC_RESET;
    end else if (clk_en) begin
      pc_load_r <= 1'b0;
      // RULE3 reset vector
      if (state_r == ric_pkg::ST_FETCH && !reset_req &&
          cnt_r == ric_pkg::CNT_W'(ric_pkg::FETCH_CYCLES - 1)) begin
        pc_load_r <= 1'b1;
        pc_load_addr_r <= ric_pkg::VEC_RESET;
      // RULE12 source vector
      end else if (fire) begin
        pc_load_r <= 1'b1;
        pc_load_addr_r <= acc_addr;
      end
    end
  end

  assign pc_load = pc_load_r;
  assign pc_load_addr = pc_load_addr_r;
  // RULE15 wake from low power
  assign mask_any = gen && (v1_req || v2_latch_r || p3_req || p4_req);
  assign stop_any = gen && (v1_req || v2_latch_r || (p3_req && VEC3_STOP_WAKE));
  // RULE26 nmi wakes only with global enable
  assign wake = (cpu_wait && ((nmi_latch_r && gen) || mask_any)) ||
                (cpu_stop && ((nmi_latch_r && gen) || stop_any));

  // apb slave, one wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (clk_en) begin
      if (psel && penable && !pready_r) begin
        pready_r <= 1'b1;
        pslverr_r <= paddr != ric_pkg::IOR_ADDR && paddr != ric_pkg::STATUS_ADDR;
        prdata_r <= '0;
        if (!pwrite && paddr == ric_pkg::STATUS_ADDR) begin
          prdata_r <= {25'h0, state_r, v2_latch_r, v1_latch_r,
                       nmi_latch_r, in_mask_r, in_nmi_r};
        end
      end else begin
        pready_r <= 1'b0;
      end
    end
  end

  assign pready = pready_r && clk_en;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  a_delay_length: assert property ( // RULE1
    (state_r == ric_pkg::ST_FETCH && $past(state_r) == ric_pkg::ST_DELAY)
    |-> $past(cnt_r) == ric_pkg::CNT_W'(RESET_DELAY - 1)) else $error("delay ended early");
  a_fetch_two: assert property ( // RULE2
    (state_r == ric_pkg::ST_RUN && $past(state_r) == ric_pkg::ST_FETCH)
    |-> $past(cnt_r) == ric_pkg::CNT_W'(ric_pkg::FETCH_CYCLES - 1))
    else $error("fetch length wrong");
  a_reset_vector: assert property ( // RULE3
    (state_r == ric_pkg::ST_RUN && $past(state_r) == ric_pkg::ST_FETCH)
    |-> pc_load && pc_load_addr == ric_pkg::VEC_RESET && int_mode_nmi)
    else $error("reset vector missing");
  a_pin_hold: assert property ( // RULE5
    (clk_en && !reset_pin_n) |=> cpu_halt && ports_pullup) else $error("pin reset not held");
  a_pin_drive: assert property ( // RULE10
    (clk_en && (lvd_low || wdg_expire)) |=> reset_pin_oe) else $error("reset pin not driven");
  a_vector_load: assert property ( // RULE12
    fire |=> pc_load && pc_load_addr == $past(acc_addr)) else $error("vector not loaded");
  a_nmi_nest: assert property ( // RULE13
    (fire && acc_src == ric_pkg::SRC_NMI) |-> !int_mode_nmi) else $error("nmi nested");
  a_mask_nest: assert property ( // RULE14
    (fire && acc_src != ric_pkg::SRC_NMI) |-> gen && !int_mode_mask && !int_mode_nmi)
    else $error("maskable nested");
  a_per_gate: assert property ( // RULE17
    (fire && acc_src == ric_pkg::SRC_V3) |-> per3_flag && per3_en && gen)
    else $error("peripheral ungated");
  a_no_wake: assert property ( // RULE26
    !gen |-> !wake) else $error("woke with global enable off");
endmodule : reset_and_interrupt_control

`default_nettype wire

// file: testbench/core_model.sv
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic pc_load,
  input wire logic [11:0] pc_load_addr,
  output logic instr_done,
  output logic [11:0] pc_r,
  output logic [15:0] load_count
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_done <= 1'b0;
    end else begin
      instr_done <= step;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_r <= 12'h000;
      load_count <= 16'h0000;
    end else if (pc_load) begin
      pc_r <= pc_load_addr;
      load_count <= load_count + 16'h0001;
    end
  end
endmodule : core_model
`default_nettype wire

// file: testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int DLY = 16;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pin_ext = 1'b1;
  logic wdg_expire = 1'b0;
  logic lvd_low = 1'b0;
  logic nmi_pin = 1'b1;
  logic vec1_pin = 1'b1;
  logic [7:0] vec2_pins = 8'hff;
  logic per3_flag = 1'b0;
  logic per3_en = 1'b0;
  logic per4_flag = 1'b0;
  logic per4_en = 1'b0;
  logic cpu_wait = 1'b0;
  logic cpu_stop = 1'b0;
  logic step = 1'b0;
  logic return_from_interrupt_instruction = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, reset_pin_o, reset_pin_oe, instr_done, cpu_halt, vec_fetch;
  logic stack_clear, ports_pullup, osc_restart, pc_load, int_mode_nmi, int_mode_mask, wake;
  logic [11:0] pc_load_addr, pc_r;
  logic [15:0] load_count;
  wire logic reset_pin_n;
  int n_mismatch = 0;
  int check_count = 0;
  // open-drain pin with pull-up
  assign reset_pin_n = reset_pin_oe ? reset_pin_o : pin_ext;
  always #5 pclk = ~pclk;
  reset_and_interrupt_control #(.RESET_DELAY(DLY), .VEC2_PINS(8), .VEC3_STOP_WAKE(1'b1)) dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .reset_pin_n, .reset_pin_o, .reset_pin_oe, .wdg_expire, .lvd_low,
    .nmi_pin, .vec1_pin, .vec2_pins, .per3_flag, .per3_en, .per4_flag, .per4_en, .cpu_wait,
    .cpu_stop, .instr_done, .return_from_interrupt_instruction, .cpu_halt, .vec_fetch,
    .stack_clear, .ports_pullup, .osc_restart, .pc_load, .pc_load_addr, .int_mode_nmi,
    .int_mode_mask, .wake);
  core_model core (.pclk, .presetn, .step, .pc_load, .pc_load_addr, .instr_done, .pc_r,
    .load_count);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : tick
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    #1;
    // only the watchdog process ends a wait that never answers
    while (pready !== 1'b1) begin
      tick(1);
    end
    // the edge that samples pready high completes the transfer
    @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic interrupt_option_reg(input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, ric_pkg::IOR_ADDR, d, rd, err);
  endtask : interrupt_option_reg
  task automatic instr(input logic [11:0] exp, input logic taken);
    logic [15:0] c0;
    c0 = load_count;
    @(posedge pclk) step <= 1'b1;
    @(posedge pclk) step <= 1'b0;
    tick(5);
    chk(32'(load_count - c0), 32'(taken));
    if (taken) chk(32'(pc_r), 32'(exp));
  endtask : instr
  task automatic ret;
    @(posedge pclk) return_from_interrupt_instruction <= 1'b1;
    @(posedge pclk) return_from_interrupt_instruction <= 1'b0;
    tick(1);
  endtask : ret
  task automatic boot;
    int n, d, f;
    n = 0;
    d = 0;
    f = 0;
    #1;
    chk({stack_clear, ports_pullup, osc_restart, cpu_halt, vec_fetch}, 5'h1e);
    while (stack_clear !== 1'b0 && n < 5000) begin
      tick(1);
      n++;
    end
    while (vec_fetch !== 1'b1 && d < 100) begin
      tick(1);
      d++;
    end
    while (vec_fetch === 1'b1 && f < 10) begin
      tick(1);
      f++;
    end
    chk(d, DLY);
    chk(f, ric_pkg::FETCH_CYCLES);
    chk({pc_load, pc_load_addr, cpu_halt}, {1'b1, ric_pkg::VEC_RESET, 1'b0});
    chk(32'(int_mode_nmi), 32'h1);
  endtask : boot
  task automatic t_regs;
    logic [31:0] rd;
    logic err;
    ret();
    chk(32'(int_mode_nmi), 32'h0);
    apb(1'b0, 8'h10, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    interrupt_option_reg(32'h0000_0040);
    apb(1'b0, ric_pkg::IOR_ADDR, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0000);
    chk(32'(err), 32'h0000_0000);
    interrupt_option_reg(32'h0000_0000);
    apb(1'b0, ric_pkg::STATUS_ADDR, 32'h0000_0000, rd, err);
    chk({rd[6:5], rd[1:0], err}, 5'h18);
  endtask : t_regs
  task automatic t_nmi;
    @(posedge pclk) nmi_pin <= 1'b0;
    instr(ric_pkg::VEC_NMI, 1'b1);
    @(posedge pclk) nmi_pin <= 1'b1;
    @(posedge pclk) nmi_pin <= 1'b0;
    instr(12'h000, 1'b0);
    ret();
    instr(ric_pkg::VEC_NMI, 1'b1);
    ret();
  endtask : t_nmi
  task automatic t_mask;
    @(posedge pclk) vec1_pin <= 1'b0;
    @(posedge pclk) vec1_pin <= 1'b1;
    @(posedge pclk) vec1_pin <= 1'b0;
    vec2_pins <= 8'hfe;
    {per3_flag, per3_en, per4_flag, per4_en} <= 4'hf;
    instr(12'h000, 1'b0);
    interrupt_option_reg(32'h0000_0010);
    instr(ric_pkg::VEC_1, 1'b1);
    chk(32'(int_mode_mask), 32'h0000_0001);
    instr(12'h000, 1'b0);
    ret();
    instr(ric_pkg::VEC_2, 1'b1);
    ret();
    instr(ric_pkg::VEC_3, 1'b1);
    @(posedge pclk) per3_flag <= 1'b0;
    ret();
    instr(ric_pkg::VEC_4, 1'b1);
    @(posedge pclk) per4_flag <= 1'b0;
    ret();
    instr(12'h000, 1'b0);
    @(posedge pclk) vec2_pins <= 8'hfc;
    per3_flag <= 1'b1;
    per3_en <= 1'b0;
    instr(12'h000, 1'b0);
    @(posedge pclk) per3_flag <= 1'b0;
  endtask : t_mask
  task automatic t_level;
    interrupt_option_reg(32'h0000_0050);
    instr(ric_pkg::VEC_1, 1'b1);
    ret();
    @(posedge pclk) vec1_pin <= 1'b1;
    instr(12'h000, 1'b0);
  endtask : t_level
  task automatic t_vec2;
    @(posedge pclk) vec2_pins <= 8'h00;
    interrupt_option_reg(32'h0000_0030);
    instr(ric_pkg::VEC_2, 1'b1);
    ret();
    @(posedge pclk) vec2_pins <= 8'h01;
    instr(ric_pkg::VEC_2, 1'b1);
    ret();
    @(posedge pclk) vec2_pins <= 8'h03;
    instr(12'h000, 1'b0);
  endtask : t_vec2
  task automatic t_wake;
    interrupt_option_reg(32'h0000_0000);
    @(posedge pclk) cpu_wait <= 1'b1;
    nmi_pin <= 1'b1;
    @(posedge pclk) nmi_pin <= 1'b0;
    tick(2);
    chk(32'(wake), 32'h0);
    interrupt_option_reg(32'h0000_0010);
    tick(1);
    chk(32'(wake), 32'h1);
    instr(ric_pkg::VEC_NMI, 1'b1);
    ret();
    @(posedge pclk) cpu_wait <= 1'b0;
    cpu_stop <= 1'b1;
    {per4_flag, per4_en} <= 2'h3;
    tick(2);
    chk(32'(wake), 32'h0);
    @(posedge pclk) per4_flag <= 1'b0;
    {per3_flag, per3_en} <= 2'h3;
    tick(2);
    chk(32'(wake), 32'h1);
    @(posedge pclk) per3_flag <= 1'b0;
  endtask : t_wake
  task automatic t_resets;
    @(posedge pclk) pin_ext <= 1'b0;
    @(posedge pclk) pin_ext <= 1'b1;
    boot();
    @(posedge pclk) cpu_stop <= 1'b0;
    pin_ext <= 1'b0;
    tick(30);
    chk({cpu_halt, ports_pullup, pc_load}, 3'h6);
    @(posedge pclk) pin_ext <= 1'b1;
    boot();
    @(posedge pclk) wdg_expire <= 1'b1;
    @(posedge pclk) wdg_expire <= 1'b0;
    #1;
    chk({reset_pin_oe, reset_pin_o}, 2'h2);
    boot();
    @(posedge pclk) lvd_low <= 1'b1;
    tick(20);
    chk({reset_pin_oe, stack_clear}, 2'h3);
    @(posedge pclk) lvd_low <= 1'b0;
    boot();
  endtask : t_resets
  task automatic conclude;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    boot();
    t_regs();
    t_nmi();
    t_mask();
    t_level();
    t_vec2();
    t_wake();
    t_resets();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
